// File: design/tom_defines.svh
// Constants for the dual-channel torque-off monitor.
`ifndef TOM_DEFINES_SVH
`define TOM_DEFINES_SVH
`define TOM_CLK_PERIOD_NS 10
`define TOM_DISC_WINDOW_NS 1000000000
`define TOM_DISC_CYCLES (`TOM_DISC_WINDOW_NS / `TOM_CLK_PERIOD_NS)
`define TOM_CLASS_NONE 3'h0
`define TOM_CLASS_STO 3'h3
`define TOM_CLASS_DISC 3'h4
`endif

// File: design/tom_monitor.sv
// Dual-channel torque-off monitor with discrepancy timing.
`timescale 1ns/100ps
`include "tom_defines.svh"
module tom_monitor #(
  parameter int unsigned DISC_CYCLES = `TOM_DISC_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic torque_off_input_a,
  input wire logic torque_off_input_b,
  input wire logic auto_power_stage_enable_setting,
  input wire logic enable_request,
  input wire logic fault_reset,
  output logic power_stage_enable,
  output tom_pkg::tom_err_t error
);
  import tom_pkg::*;

  // Three-stage synchronisers; a change counts once stages two and three agree.
  logic [2:0] sa_r;
  logic [2:0] sb_r;
  logic fa_r;
  logic fb_r;
  logic fa_nxt;
  logic fb_nxt;
  always_comb begin
    fa_nxt = (sa_r[1] == sa_r[2]) ? sa_r[2] : fa_r;
    fb_nxt = (sb_r[1] == sb_r[2]) ? sb_r[2] : fb_r;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sa_r <= 3'h0;
      sb_r <= 3'h0;
      fa_r <= 1'b0;
      fb_r <= 1'b0;
    end else begin
      sa_r <= {sa_r[1:0], torque_off_input_a};
      sb_r <= {sb_r[1:0], torque_off_input_b};
      fa_r <= fa_nxt;
      fb_r <= fb_nxt;
    end
  end

  // A low level on an input is a torque-off request; no inversion exists.
  logic lo_a;
  logic lo_b;
  assign lo_a = ~fa_r;
  assign lo_b = ~fb_r;

  tom_state_t state_r;
  tom_state_t state_nxt;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic [2:0] cls_r;
  logic [2:0] cls_nxt;
  logic en_r;
  logic en_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    cls_nxt = cls_r;
    en_nxt = en_r;
    unique case (state_r)
      TOM_RUN: begin
        if (lo_a || lo_b) begin
          en_nxt = 1'b0;
          cls_nxt = `TOM_CLASS_STO;
          cnt_nxt = 32'h0;
          state_nxt = (lo_a && lo_b) ? TOM_OFF : TOM_WAIT;
        end else if (cls_r != `TOM_CLASS_NONE) begin
          if (fault_reset) begin
            cls_nxt = `TOM_CLASS_NONE;
          end
        end else if (enable_request || auto_power_stage_enable_setting) begin
          en_nxt = 1'b1;
        end
      end
      TOM_WAIT: begin
        en_nxt = 1'b0;
        if (lo_a && lo_b) begin
          state_nxt = TOM_OFF;
        end else if (cnt_r >= DISC_CYCLES - 1) begin
          cls_nxt = `TOM_CLASS_DISC;
          state_nxt = TOM_OFF;
        end else begin
          cnt_nxt = cnt_r + 32'h1;
        end
      end
      TOM_OFF: begin
        en_nxt = 1'b0;
        if (!lo_a && !lo_b) begin
          state_nxt = TOM_RUN;
        end
      end
      default: begin
        state_nxt = TOM_OFF;
        en_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= TOM_OFF;
      cnt_r <= 32'h0;
      cls_r <= `TOM_CLASS_NONE;
      en_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      cls_r <= cls_nxt;
      en_r <= en_nxt;
    end
  end

  // The enable also drops combinationally on any synchronised low level.
  assign power_stage_enable = en_r & ~lo_a & ~lo_b;
  assign error.active = (cls_r != `TOM_CLASS_NONE);
  assign error.err_class = cls_r;
  // No brake output exists; braking must come from outside the block.

  sequence s_first_low;
    (state_r == TOM_RUN) && (lo_a || lo_b);
  endsequence

  chk_off_disables: assert property (@(posedge mclk) disable iff (rst)
    (lo_a || lo_b) |-> !power_stage_enable)
    else $error("power stage enabled while an input is low");
  chk_class_three: assert property (@(posedge mclk) disable iff (rst)
    s_first_low |=> (cls_r == `TOM_CLASS_STO))
    else $error("class 3 not recorded on torque off");
  chk_class_kept: assert property (@(posedge mclk) disable iff (rst)
    (state_r == TOM_WAIT && lo_a && lo_b) |=> (cls_r == `TOM_CLASS_STO))
    else $error("class changed though second input followed");
  chk_class_four: assert property (@(posedge mclk) disable iff (rst)
    (state_r == TOM_WAIT && !(lo_a && lo_b) && cnt_r >= DISC_CYCLES - 1)
    |=> (cls_r == `TOM_CLASS_DISC && state_r == TOM_OFF))
    else $error("class 4 not raised after discrepancy window");
  chk_polarity: assert property (@(posedge mclk) disable iff (rst)
    power_stage_enable |-> (fa_r && fb_r))
    else $error("enabled without both inputs high");
  chk_timer_bound: assert property (@(posedge mclk) disable iff (rst)
    (state_r == TOM_WAIT) |-> (cnt_r < DISC_CYCLES))
    else $error("discrepancy timer overran");
  chk_timer_start: assert property (@(posedge mclk) disable iff (rst)
    (s_first_low ##1 (state_r == TOM_WAIT)) |-> (cnt_r == 32'h0))
    else $error("discrepancy timer not cleared at start");
  chk_wait_stops: assert property (@(posedge mclk) disable iff (rst)
    (state_r == TOM_WAIT && lo_a && lo_b) |=> (state_r == TOM_OFF) ##1 $stable(cls_r))
    else $error("wait not ended by second input");

  // Multi-step behaviours built from named sequences.
  sequence s_both_high;
    !lo_a && !lo_b;
  endsequence

  sequence s_wait_timeout;
    (state_r == TOM_WAIT) && !(lo_a && lo_b) && (cnt_r >= DISC_CYCLES - 1);
  endsequence

  sequence s_off_release;
    (state_r == TOM_OFF) ##0 s_both_high;
  endsequence

  // A low level must keep the registered enable down on the following edge.
  chk_low_blocks: assert property (@(posedge mclk) disable iff (rst)
    (lo_a || lo_b) |=> !en_r)
    else $error("enable register set while an input was low");

  chk_stopped_off: assert property (@(posedge mclk) disable iff (rst)
    (state_r != TOM_RUN) |-> !en_r)
    else $error("enable register high outside the run state");

  chk_both_low_off: assert property (@(posedge mclk) disable iff (rst)
    (s_first_low ##0 (lo_a && lo_b)) |=> (state_r == TOM_OFF))
    else $error("simultaneous low did not enter the off state");

  // A recorded error refuses any enable until it is cleared.
  chk_error_refuses: assert property (@(posedge mclk) disable iff (rst)
    (cls_r != `TOM_CLASS_NONE && !en_r) |=> !en_r)
    else $error("enable granted while an error was recorded");

  chk_wait_class: assert property (@(posedge mclk) disable iff (rst)
    (state_r == TOM_WAIT) |-> (cls_r == `TOM_CLASS_STO))
    else $error("class other than 3 during the discrepancy wait");

  chk_class_legal: assert property (@(posedge mclk) disable iff (rst)
    (cls_r == `TOM_CLASS_NONE) || (cls_r == `TOM_CLASS_STO) || (cls_r == `TOM_CLASS_DISC))
    else $error("illegal error class recorded");

  chk_fault_clear: assert property (@(posedge mclk) disable iff (rst)
    (state_r == TOM_RUN && !lo_a && !lo_b && cls_r != `TOM_CLASS_NONE && fault_reset)
    |=> (cls_r == `TOM_CLASS_NONE))
    else $error("fault reset did not clear the error");

  // Once off, the class must not change until the run state is reached again.
  chk_off_class: assert property (@(posedge mclk) disable iff (rst)
    (state_r == TOM_OFF) |=> $stable(cls_r))
    else $error("class changed in the off state");

  chk_timeout_off: assert property (@(posedge mclk) disable iff (rst)
    s_wait_timeout |=> (state_r == TOM_OFF) ##1 (cls_r == `TOM_CLASS_DISC))
    else $error("class 4 not kept after the discrepancy window");

  chk_release_run: assert property (@(posedge mclk) disable iff (rst)
    s_off_release |=> (state_r == TOM_RUN))
    else $error("both inputs high did not return to run");

  // The filtered level follows stage three only when stages two and three agree.
  chk_sync_a: assert property (@(posedge mclk) disable iff (rst)
    (sa_r[1] == sa_r[2]) |=> (fa_r == $past(sa_r[2])))
    else $error("channel a filter did not follow agreed stages");

  chk_sync_b: assert property (@(posedge mclk) disable iff (rst)
    (sb_r[1] == sb_r[2]) |=> (fb_r == $past(sb_r[2])))
    else $error("channel b filter did not follow agreed stages");

  chk_auto_enable: assert property (@(posedge mclk) disable iff (rst)
    (state_r == TOM_RUN && !lo_a && !lo_b && cls_r == `TOM_CLASS_NONE &&
    auto_power_stage_enable_setting) |=> en_r)
    else $error("automatic enable did not set the power stage");

  chk_wait_entry: assert property (@(posedge mclk) disable iff (rst)
    (s_first_low ##0 !(lo_a && lo_b)) |=> (state_r == TOM_WAIT))
    else $error("single low did not start the discrepancy wait");

  chk_timer_step: assert property (@(posedge mclk) disable iff (rst)
    (state_r == TOM_WAIT && !(lo_a && lo_b) && cnt_r < DISC_CYCLES - 1)
    |=> (cnt_r == $past(cnt_r) + 32'h1))
    else $error("discrepancy timer did not advance by one");
endmodule

// File: design/tom_pkg.sv
// Types for the dual-channel torque-off monitor.
package tom_pkg;
  typedef enum logic [1:0] {
    TOM_RUN = 2'b00,
    TOM_WAIT = 2'b01,
    TOM_OFF = 2'b10
  } tom_state_t;
  typedef struct packed {
    logic active;
    logic [2:0] err_class;
  } tom_err_t;
endpackage

// File: testbench/tom_estop.sv
// Emergency-stop model driving both torque-off channels.
`timescale 1ns/100ps
module tom_estop (
  input wire logic mclk,
  input wire logic trip,
  input wire logic [7:0] skew,
  output logic chan_a,
  output logic chan_b
);
  logic [7:0] cnt_r = 8'h00;
  initial begin
    chan_a = 1'b1;
    chan_b = 1'b1;
  end
  // Channel A opens on the trip and B follows skew cycles later.
  always @(negedge mclk) begin
    chan_a <= !trip;
    cnt_r <= trip ? cnt_r + 8'h01 : 8'h00;
    chan_b <= !(trip && cnt_r >= skew);
  end
endmodule

// File: testbench/tom_monitor_tb_top.sv
// Self-checking bench for the torque-off monitor.
`timescale 1ns/100ps
module tom_monitor_tb_top;
  import tom_pkg::*;
  localparam int DISC = 50;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic trip = 1'b0;
  logic en_req = 1'b0;
  logic flt_rst = 1'b0;
  logic auto_en = 1'b0;
  logic [7:0] skew = 8'h00;
  logic chan_a, chan_b, pse;
  tom_err_t err;
  int error_cnt = 0;
  int comparisons = 0;
  int seed = 32'h3114d1ca;
  always #5 mclk = ~mclk;
  tom_estop i_tom_estop (.mclk(mclk), .trip(trip), .skew(skew), .chan_a(chan_a),
    .chan_b(chan_b));
  tom_monitor #(.DISC_CYCLES(DISC)) i_tom_monitor (.mclk(mclk), .rst(rst),
    .torque_off_input_a(chan_a), .torque_off_input_b(chan_b),
    .auto_power_stage_enable_setting(auto_en), .enable_request(en_req),
    .fault_reset(flt_rst), .power_stage_enable(pse), .error(err));
  task automatic cmp(input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // A second channel lagging past the window escalates the class.
  function automatic logic [3:0] exp_err(input int s);
    return {1'b1, (s < DISC) ? 3'h3 : 3'h4};
  endfunction
  task automatic results;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    cyc(16);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < 2)
        skew <= 8'(i * 40);
      else if (i[0])
        skew <= 8'(60 + ($random(seed) & 15));
      else
        skew <= 8'($random(seed) & 31);
      auto_en <= i[1];
      cyc(8);
      flt_rst <= 1'b1;
      cyc(1);
      flt_rst <= 1'b0;
      cyc(1);
      en_req <= !i[1];
      cyc(1);
      en_req <= 1'b0;
      cyc(2);
      cmp({3'h0, pse}, 4'h1);
      trip <= 1'b1;
      cyc(6);
      cmp({3'h0, pse}, 4'h0);
      cmp(err, 4'hb);
      cyc(DISC + 30);
      cmp(err, exp_err(skew));
      trip <= 1'b0;
      cyc(8);
      en_req <= 1'b1;
      cyc(2);
      en_req <= 1'b0;
      cmp({3'h0, pse}, 4'h0);
    end
    results();
  end
endmodule
